/* File: design/sscr_params.svh */
// Constants for the standstill current reducer
`ifndef SSCR_PARAMS_SVH
`define SSCR_PARAMS_SVH
// ==========================================
// Field widths
`define SSCR_CUR_W 8
`define SSCR_FALL_W 4
`define SSCR_DLY_W 6
// ==========================================
// Timing
`define SSCR_CLK_HZ 10000000
`define SSCR_FALL_UNIT_MS 1
`define SSCR_DLY_UNIT_MS 16
`define SSCR_MS_CYCLES (`SSCR_CLK_HZ / 1000)
`define SSCR_FALL_UNIT_CYC (`SSCR_FALL_UNIT_MS * `SSCR_MS_CYCLES)
`define SSCR_DLY_UNIT_CYC (`SSCR_DLY_UNIT_MS * `SSCR_MS_CYCLES)
// ==========================================
// Reset values and special codes
`define SSCR_FALL_RST 4'h1
`define SSCR_DLY_RST 6'h01
`define SSCR_FALL_ZERO 4'h0
`define SSCR_DLY_RSVD 6'h00
`endif

/* File: design/sscr_pkg.sv */
// Types for the standstill current reducer
`default_nettype none
`include "sscr_params.svh"
package sscr_pkg;
	typedef enum logic [1:0] {
		SSCR_RUN,
		SSCR_WAIT,
		SSCR_RAMP,
		SSCR_HOLD
	} sscr_state_t;

	typedef struct packed {
		logic standstill_saving_enable;
		logic [`SSCR_FALL_W-1:0] standstill_fall_step_time;
		logic [`SSCR_DLY_W-1:0] standstill_entry_delay;
		logic [`SSCR_CUR_W-1:0] run_current_level;
		logic [`SSCR_CUR_W-1:0] holding_current_level;
	} sscr_cfg_t;
endpackage
`default_nettype wire

/* File: design/sscr_sync.sv */
// Two-stage synchroniser with rising-edge pulse
`default_nettype none
`include "sscr_params.svh"
module sscr_sync (
	// Clock and reset
	input wire logic clk_in,
	input wire logic reset_n_in,
	input wire logic clk_en_in,
	// Asynchronous level and results
	input wire logic async_in,
	output logic level_out,
	output logic rise_out
);
	logic meta_q;
	logic sync_q;
	logic last_q;

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
			last_q <= 1'b0;
		end else if (clk_en_in) begin
			meta_q <= async_in;
			sync_q <= meta_q;
			last_q <= sync_q;
		end
	end

	assign level_out = sync_q;
	assign rise_out = sync_q & ~last_q;
endmodule
`default_nettype wire

/* File: design/sscr_tick.sv */
// Restartable prescaler giving a one-cycle tick every TICK_CYC cycles
`default_nettype none
`include "sscr_params.svh"
module sscr_tick #(
	parameter int TICK_CYC = `SSCR_MS_CYCLES
) (
	// Clock and reset
	input wire logic clk_in,
	input wire logic reset_n_in,
	input wire logic clk_en_in,
	// Restart and tick
	input wire logic restart_in,
	output logic tick_out
);
	localparam int CW = (TICK_CYC > 1) ? $clog2(TICK_CYC) : 1;
	logic [CW-1:0] cnt_q;

	initial begin
		if (TICK_CYC < 2) begin
			$error("sscr_tick: TICK_CYC must be at least 2");
		end
	end

	// Restart keeps the time base aligned to the last step
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			cnt_q <= '0;
		end else if (clk_en_in) begin
			if (restart_in || cnt_q == CW'(TICK_CYC - 1)) begin
				cnt_q <= '0;
			end else begin
				cnt_q <= cnt_q + 1'b1;
			end
		end
	end

	assign tick_out = clk_en_in && !restart_in && cnt_q == CW'(TICK_CYC - 1);
endmodule
`default_nettype wire

/* File: design/sscr_core.sv */
// Standstill current reducer: delay, ramp-down and holding of the current target
// Notes on behaviour
// - Standstill reduction only while enable is 1; otherwise target stays at run level.
// - Count entry delay after last step; reduce only when it expires quietly.
// - After delay, move target from run level toward holding level over fall period.
// - Lower code by one per fall-step interval; stop at holding level.
// - Raise standstill-active flag while in power-saving mode.
// - Step during delay, ramp or hold restores run level and clears flag at once.
// - Fall-step code 0 drops at once; code n gives n ms per current step.
// - Entry delay is code times 16 ms; code 0 is reserved.
// - Run level from torque current input, holding level from holding input.
`default_nettype none
`include "sscr_params.svh"
module sscr_core
	import sscr_pkg::*;
#(
	parameter int MS_CYC = `SSCR_MS_CYCLES,
	parameter int CUR_W = `SSCR_CUR_W
) (
	// Clock, enable and reset
	input wire logic clk_in,
	input wire logic clk_en_in,
	input wire logic reset_n_in,
	// Step pin from the motion controller
	input wire logic step_in,
	// Register fields written over the serial port
	input wire sscr_cfg_t cfg_in,
	// Results
	output logic [CUR_W-1:0] current_target_out,
	output logic standstill_active_flag_out
);
	// ==========================================
	// Elaboration checks
	initial begin
		if (CUR_W != `SSCR_CUR_W) begin
			$error("sscr_core: CUR_W must match the configuration struct");
		end
		if (MS_CYC < 2) begin
			$error("sscr_core: MS_CYC must be at least 2");
		end
	end

	// ==========================================
	// Step pin synchronisation
	logic step_rise;

	sscr_sync u_sync (
		.clk_in(clk_in),
		.reset_n_in(reset_n_in),
		.clk_en_in(clk_en_in),
		.async_in(step_in),
		.level_out(),
		.rise_out(step_rise)
	);

	// ==========================================
	// Millisecond time base, realigned on each step
	logic ms_tick;

	sscr_tick #(
		.TICK_CYC(MS_CYC)
	) u_tick (
		.clk_in(clk_in),
		.reset_n_in(reset_n_in),
		.clk_en_in(clk_en_in),
		.restart_in(step_rise),
		.tick_out(ms_tick)
	);

	// ==========================================
	// Register field latch from the ports
	logic enable_q;
	logic [`SSCR_FALL_W-1:0] fall_q;
	logic [`SSCR_DLY_W-1:0] dly_q;
	logic [CUR_W-1:0] run_q;
	logic [CUR_W-1:0] hold_q;

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			enable_q <= 1'b0;
			fall_q <= `SSCR_FALL_RST;
			dly_q <= `SSCR_DLY_RST;
			run_q <= '0;
			hold_q <= '0;
		end else if (clk_en_in) begin
			enable_q <= cfg_in.standstill_saving_enable;
			fall_q <= cfg_in.standstill_fall_step_time;
			dly_q <= cfg_in.standstill_entry_delay;
			run_q <= cfg_in.run_current_level;
			hold_q <= cfg_in.holding_current_level;
		end
	end

	// ==========================================
	// Decoding helpers
	// Reserved delay code 0 is treated as code 1 so the mode never fires early
	function automatic logic [`SSCR_DLY_W+4-1:0] dly_ms(input logic [`SSCR_DLY_W-1:0] code);
		logic [`SSCR_DLY_W-1:0] c;
		c = (code == `SSCR_DLY_RSVD) ? `SSCR_DLY_RST : code;
		return {c, 4'h0};
	endfunction

	// ==========================================
	// State machine
	sscr_state_t state_q;
	logic [`SSCR_DLY_W+4-1:0] ms_cnt_q;
	logic [CUR_W-1:0] target_q;
	logic abort;

	assign abort = step_rise || !enable_q;

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			state_q <= SSCR_RUN;
			ms_cnt_q <= '0;
		end else if (clk_en_in) begin
			unique case (state_q)
				SSCR_RUN: begin
					ms_cnt_q <= '0;
					if (enable_q && !step_rise) begin
						state_q <= SSCR_WAIT;
					end
				end
				SSCR_WAIT: begin
					if (abort) begin
						state_q <= SSCR_RUN;
						ms_cnt_q <= '0;
					end else if (ms_tick) begin
						if (ms_cnt_q + 1'b1 >= dly_ms(dly_q)) begin
							state_q <= SSCR_RAMP;
							ms_cnt_q <= '0;
						end else begin
							ms_cnt_q <= ms_cnt_q + 1'b1;
						end
					end
				end
				SSCR_RAMP: begin
					if (abort) begin
						state_q <= SSCR_RUN;
						ms_cnt_q <= '0;
					end else if (target_q <= hold_q) begin
						state_q <= SSCR_HOLD;
					end else if (fall_q == `SSCR_FALL_ZERO) begin
						state_q <= SSCR_HOLD;
					end else if (ms_tick) begin
						if (ms_cnt_q + 1'b1 >= {6'h00, fall_q}) begin
							ms_cnt_q <= '0;
						end else begin
							ms_cnt_q <= ms_cnt_q + 1'b1;
						end
					end
				end
				SSCR_HOLD: begin
					if (abort) begin
						state_q <= SSCR_RUN;
						ms_cnt_q <= '0;
					end
				end
			endcase
		end
	end

	// Step tick of the ramp, shared by the target update
	logic ramp_step;
	assign ramp_step = state_q == SSCR_RAMP && !abort && ms_tick && fall_q != `SSCR_FALL_ZERO
		&& ms_cnt_q + 1'b1 >= {6'h00, fall_q};

	// ==========================================
	// Current target
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			target_q <= '0;
		end else if (clk_en_in) begin
			if (state_q == SSCR_RUN || state_q == SSCR_WAIT || abort) begin
				target_q <= run_q;
			end else if (state_q == SSCR_RAMP) begin
				if (target_q <= hold_q || fall_q == `SSCR_FALL_ZERO) begin
					target_q <= hold_q;
				end else if (ramp_step) begin
					target_q <= target_q - 1'b1;
				end
			end
		end
	end

	// ==========================================
	// Status flag: set for ramp and hold
	logic flag_q;
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			flag_q <= 1'b0;
		end else if (clk_en_in) begin
			flag_q <= !abort && (state_q == SSCR_RAMP || state_q == SSCR_HOLD
				|| (state_q == SSCR_WAIT && ms_tick
				&& ms_cnt_q + 1'b1 >= dly_ms(dly_q)));
		end
	end

	assign current_target_out = target_q;
	assign standstill_active_flag_out = flag_q;

	// ==========================================
	// Checks
	sequence s_abort;
		clk_en_in && abort;
	endsequence

	a_abort_restores: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		s_abort |=> (current_target_out == $past(run_q)) && !standstill_active_flag_out)
		else $error("abort did not restore run level");
	a_disable_run: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		clk_en_in && !enable_q |=> !standstill_active_flag_out)
		else $error("flag raised while disabled");
	a_ramp_single: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		clk_en_in && state_q == SSCR_RAMP && !abort && fall_q != `SSCR_FALL_ZERO
		&& target_q > hold_q |=> target_q == $past(target_q)
		|| target_q == $past(target_q) - 1'b1)
		else $error("ramp moved by more than one code");
	a_hold_level: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		clk_en_in && state_q == SSCR_HOLD && !abort |=> target_q == $past(target_q))
		else $error("holding level drifted");
	a_flag_in_hold: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		state_q == SSCR_HOLD && $past(state_q) == SSCR_HOLD |-> standstill_active_flag_out)
		else $error("flag low while holding");
	a_zero_fall: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		clk_en_in && state_q == SSCR_RAMP && !abort && fall_q == `SSCR_FALL_ZERO
		|=> target_q == $past(hold_q))
		else $error("zero fall time did not drop at once");
	a_step_restart: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		clk_en_in && step_rise |=> state_q == SSCR_RUN)
		else $error("step did not restart delay");
	a_delay_min: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		clk_en_in && state_q == SSCR_WAIT && ms_cnt_q == '0 && !ms_tick
		|=> state_q != SSCR_RAMP)
		else $error("ramp began before delay");

	// ==========================================
	// Multi-step checks, the first two built from named sequences
	sequence s_wait_expire;
		clk_en_in && state_q == SSCR_WAIT && !abort && ms_tick
		&& ms_cnt_q + 1'b1 >= dly_ms(dly_q);
	endsequence

	sequence s_ramp_step;
		clk_en_in && ramp_step && target_q > hold_q;
	endsequence

	a_expire_flag: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		s_wait_expire |=> standstill_active_flag_out && state_q == SSCR_RAMP)
		else $error("delay expiry did not raise flag");

	a_ramp_down: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		s_ramp_step |=> target_q == $past(target_q) - 1'b1)
		else $error("ramp step did not lower code by one");

	a_disabled_run: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		clk_en_in && !enable_q && state_q == SSCR_RUN |=> target_q == $past(run_q))
		else $error("disabled target left run level");

	// Freeze must hold the state register too, not only the target and the flag
	a_freeze_state: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		!clk_en_in |=> $stable(target_q) && $stable(state_q) && $stable(flag_q))
		else $error("state moved while clock enable low");

	a_run_no_flag: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		clk_en_in && state_q == SSCR_RUN |=> !standstill_active_flag_out)
		else $error("flag raised in run state");

	a_hold_stop: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		clk_en_in && state_q == SSCR_RAMP && !abort && target_q <= hold_q
		|=> state_q == SSCR_HOLD && target_q == $past(hold_q))
		else $error("ramp did not stop at holding level");

	a_wait_target: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		clk_en_in && state_q == SSCR_WAIT |=> target_q == $past(run_q))
		else $error("target reduced before delay expired");

	a_zero_fall_hold: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		clk_en_in && state_q == SSCR_RAMP && !abort && fall_q == `SSCR_FALL_ZERO
		|=> state_q == SSCR_HOLD)
		else $error("zero fall time did not reach hold");

	// Reserved code must behave as the shortest delay, never shorter
	a_rsvd_delay: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		clk_en_in && state_q == SSCR_WAIT && ms_tick && dly_q == `SSCR_DLY_RSVD
		&& ms_cnt_q < 10'h00e |=> state_q != SSCR_RAMP)
		else $error("reserved delay code ended wait early");

	a_ramp_flag: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		clk_en_in && state_q == SSCR_RAMP && !abort |=> standstill_active_flag_out)
		else $error("flag low during ramp");

	a_step_clear: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		clk_en_in && step_rise && state_q != SSCR_RUN
		|=> !standstill_active_flag_out && target_q == $past(run_q))
		else $error("step did not restore run level");
endmodule
`default_nettype wire

/* File: verification/sscr_ctrl_model.sv */
// Motion controller model: step pin and register fields
`default_nettype none
module sscr_ctrl_model
	import sscr_pkg::*;
#(
	parameter int ATQ_FLOOR = 4,
	parameter int ATQ_CEIL = 200
) (
	// Clock
	input wire logic clk_in,
	// Pin and fields toward the device
	output var logic step_out,
	output var sscr_cfg_t cfg_out
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		step_out = 1'b0;
		cfg_out = {1'b0, 4'h1, 6'h01, 8'h00, 8'h00};
	end
	// ==========================================
	// Step pulse, two cycles wide so the synchroniser sees it
	task automatic step_pulse();
		@(negedge clk_in);
		step_out = 1'b1;
		repeat (2) @(negedge clk_in);
		step_out = 1'b0;
	endtask
	// ==========================================
	// Register write
	task automatic write_cfg(input logic en, input logic [3:0] fall, input logic [5:0] dly,
		input logic [7:0] run, input logic [7:0] hold);
		logic [7:0] h;
		h = (hold < 8'(ATQ_FLOOR)) ? 8'(ATQ_FLOOR) : hold;
		h = (h > 8'(ATQ_CEIL)) ? 8'(ATQ_CEIL) : h;
		@(negedge clk_in);
		if (cfg_out.standstill_saving_enable && h !== cfg_out.holding_current_level) begin
			cfg_out.standstill_saving_enable = 1'b0;
			repeat (2) @(negedge clk_in);
		end
		cfg_out = {en, fall, dly, run, h};
	endtask
endmodule
`default_nettype wire

/* File: verification/standstill_current_reducer_tb.sv */
// Self-checking bench for the standstill current reducer
`default_nettype none
module standstill_current_reducer_tb
	import sscr_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int MS = 4;
	localparam int LIMIT = 20000;
	typedef struct {logic [7:0] tgt; logic flag; int lo; int hi;} sscr_note_t;
	logic clk_in = 1'b0;
	logic reset_n_in = 1'b0;
	logic clk_en_in = 1'b1;
	logic step;
	sscr_cfg_t cfg;
	logic [7:0] target;
	logic flag;
	logic [7:0] run;
	logic [7:0] prev_tgt = 8'h00;
	sscr_note_t notes[$];
	int n_mismatch = 0;
	int compares = 0;
	int cyc = 0;
	int ref_cyc = 0;
	always #50 clk_in = ~clk_in;
	sscr_ctrl_model sscr_ctrl_model_i (.clk_in(clk_in), .step_out(step), .cfg_out(cfg));
	sscr_core #(.MS_CYC(MS)) sscr_core_i (.clk_in(clk_in), .clk_en_in(clk_en_in),
		.reset_n_in(reset_n_in), .step_in(step), .cfg_in(cfg),
		.current_target_out(target), .standstill_active_flag_out(flag));
	// ==========================================
	// Checking and closing
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic give_verdict();
		$display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic note(input logic [7:0] t, input logic f, input int lo, input int hi);
		notes.push_back('{t, f, lo, hi});
	endtask
	task automatic drain();
		for (int n = 0; n < 3000 && notes.size() > 0; n++) @(negedge clk_in);
		chk(notes.size(), 0);
		repeat (20) @(negedge clk_in);
	endtask
	always @(posedge clk_in) begin
		cyc++;
		if (cyc >= LIMIT) begin
			n_mismatch++;
			give_verdict();
		end
	end
	// Every change of target must match the oldest note, timing included
	always @(negedge clk_in) begin
		sscr_note_t nt;
		if (target !== prev_tgt) begin
			if (notes.size() == 0) begin
				chk(target, prev_tgt);
			end else begin
				nt = notes.pop_front();
				chk(target, nt.tgt);
				chk(flag, nt.flag);
				chk(cyc - ref_cyc >= nt.lo && cyc - ref_cyc <= nt.hi, 1);
			end
			prev_tgt = target;
			ref_cyc = cyc;
		end
	end
	// ==========================================
	// One standstill episode, ended by a step or by clearing enable
	task automatic stand(input logic [3:0] fall, input logic [5:0] dly, input int drop,
		input bit by_step, input bit retrig, input int cut);
		int d;
		int f;
		d = ((dly == 6'h00) ? 1 : int'(dly)) * 16 * MS;
		f = int'(fall) * MS;
		sscr_ctrl_model_i.write_cfg(1'b1, fall, dly, run, run - 8'(drop));
		ref_cyc = cyc;
		sscr_ctrl_model_i.step_pulse();
		// Steps closer than the delay keep it from expiring
		for (int i = 0; retrig && i < 3; i++) begin
			repeat (d - 24) @(negedge clk_in);
			ref_cyc = cyc;
			sscr_ctrl_model_i.step_pulse();
		end
		if (fall == 4'h0) begin
			note(run - 8'(drop), 1'b1, d, d + 10);
		end else begin
			note(run - 8'h01, 1'b1, d, d + f + 10);
			for (int k = 2; k <= drop; k++) note(run - 8'(k), 1'b1, f, f);
		end
		for (int n = 0; n < 3000 && notes.size() > cut; n++) @(negedge clk_in);
		notes.delete();
		note(run, 1'b0, 1, 7);
		ref_cyc = cyc;
		if (by_step) begin
			sscr_ctrl_model_i.step_pulse();
		end else begin
			sscr_ctrl_model_i.write_cfg(1'b0, fall, dly, run, run - 8'(drop));
		end
		drain();
	endtask
	// ==========================================
	// Main sequence
	initial begin
		void'($urandom(55));
		run = 8'(20 + $urandom_range(0, 100));
		sscr_ctrl_model_i.write_cfg(1'b0, 4'h1, 6'h01, run, run - 8'h03);
		note(run, 1'b0, 0, LIMIT);
		repeat (8) @(negedge clk_in);
		reset_n_in = 1'b1;
		drain();
		sscr_ctrl_model_i.step_pulse();
		repeat (200) @(negedge clk_in);
		chk(target, run);
		// Clock enable low freezes the block even with saving enabled
		clk_en_in = 1'b0;
		sscr_ctrl_model_i.write_cfg(1'b1, 4'h0, 6'h01, run, run - 8'h03);
		repeat (200) @(negedge clk_in);
		chk(target, run);
		chk(flag, 1'b0);
		clk_en_in = 1'b1;
		sscr_ctrl_model_i.write_cfg(1'b0, 4'h0, 6'h01, run, run - 8'h03);
		repeat (20) @(negedge clk_in);
		chk(target, run);
		stand(4'h1, 6'h01, $urandom_range(1, 4), 1'b1, 1'b0, 0);
		stand(4'h0, 6'h02, $urandom_range(2, 9), 1'b0, 1'b0, 0);
		stand(4'h2, 6'h00, 2, 1'b1, 1'b1, 0);
		stand(4'h3, 6'h01, 4, 1'b1, 1'b0, 2);
		// Reset in mid-run clears target, then run level returns
		note(8'h00, 1'b0, 0, LIMIT);
		note(run, 1'b0, 0, LIMIT);
		reset_n_in = 1'b0;
		repeat (3) @(negedge clk_in);
		reset_n_in = 1'b1;
		drain();
		give_verdict();
	end
endmodule
`default_nettype wire
